// *** logic/sad_decoder.sv ***
// Five-master address decoder with boot select, remap and SRAM split.
`timescale 1ns/1ps
`default_nettype none

module sad_decoder
  import sad_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Boot strap pin, asynchronous to the clock.
  input wire logic i_boot_memory_select,
  // Configuration bits.
  input wire logic i_swap_bit_instr_master,
  input wire logic i_swap_bit_data_master,
  input wire sad_size_t i_size_sram_a,
  input wire sad_size_t i_size_sram_b,
  // Master requests: a pulse of valid starts a transfer.
  input wire sad_req_t [N_MASTERS-1:0] i_req,
  // Transfer completion per master, ends the transfer in progress.
  input wire logic [N_MASTERS-1:0] i_done,
  // Decoded routes, one per master.
  output sad_route_t [N_MASTERS-1:0] o_route,
  // Arbiter grants per slave, one-hot master number.
  output logic [N_SLAVES-1:0][N_MASTERS-1:0] o_grant,
  // State visible to software.
  output logic o_boot_rom,
  output logic [3:0] o_sram_c_blocks
);

  // Number of blocks for a size code.
  function automatic logic [3:0] blocks_of(input sad_size_t sz);
    unique case (sz)
      SAD_SZ_0K: blocks_of = 4'h0;
      SAD_SZ_16K: blocks_of = 4'h1;
      SAD_SZ_32K: blocks_of = 4'h2;
      SAD_SZ_64K: blocks_of = 4'h4;
    endcase
  endfunction

  // Boot strap synchroniser and capture.
  logic boot_meta_ff;
  logic boot_sync_ff;
  logic boot_taken_ff;
  logic boot_rom_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_meta_ff <= 1'b0;
      boot_sync_ff <= 1'b0;
    end else begin
      boot_meta_ff <= i_boot_memory_select;
      boot_sync_ff <= boot_meta_ff;
    end
  end

  // Edges after release are counted so the strap is taken only once both
  // synchroniser stages hold the pin and no longer their reset value.
  logic [1:0] boot_wait_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_wait_ff <= 2'h0;
    end else if (boot_wait_ff != 2'h2) begin
      boot_wait_ff <= boot_wait_ff + 2'h1;
    end
  end

  // The pin is caught once, on the third edge after release, then held.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_taken_ff <= 1'b0;
      boot_rom_ff <= 1'b0;
    end else if (!boot_taken_ff && boot_wait_ff == 2'h2) begin
      boot_taken_ff <= 1'b1;
      boot_rom_ff <= boot_sync_ff;
    end
  end

  // Live configuration; a whole-bus idle is needed before it is adopted.
  logic [N_MASTERS-1:0] busy_ff;
  logic [N_MASTERS-1:0] nxt_busy;
  logic [1:0] remap_ff;
  logic [3:0] a_blocks_ff;
  logic [3:0] b_blocks_ff;
  logic idle;

  // Waiting for a whole-bus idle costs latency on a busy bus, but keeps
  // every open route pointing at the memory that it started on.
  assign idle = (busy_ff == '0) && (i_req_valid_any() == 1'b0);

  function automatic logic i_req_valid_any();
    logic any;
    any = 1'b0;
    for (int m = 0; m < N_MASTERS; m++) begin
      any = any | i_req[m].valid;
    end
    i_req_valid_any = any;
  endfunction

  // Reset gives all ten blocks to SRAM C and clears remap.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      remap_ff <= 2'b00;
      a_blocks_ff <= 4'h0;
      b_blocks_ff <= 4'h0;
    end else if (idle) begin
      // Only adopted with no transfer open, so a route never changes.
      remap_ff <= {i_swap_bit_data_master, i_swap_bit_instr_master};
      a_blocks_ff <= blocks_of(i_size_sram_a);
      b_blocks_ff <= blocks_of(i_size_sram_b);
    end
  end

  // SRAM C always keeps at least the two fixed blocks.
  // A and B together never ask for more than eight blocks, so this
  // subtraction cannot eat into the two blocks kept for SRAM C.
  logic [3:0] c_blocks;
  assign c_blocks = N_BLOCKS - a_blocks_ff - b_blocks_ff;

  // True when the 16 Kbyte block of an offset lies inside an area.
  // Every SRAM window clips through here, so all areas abort alike.
  function automatic logic in_area(input logic [19:0] off,
                                   input logic [3:0] blocks);
    logic [5:0] blk;
    blk = off[19:BLK_SHIFT];
    in_area = blk < {2'b00, blocks};
  endfunction

  // Second stage inside region zero, in 1 Mbyte windows.
  function automatic sad_route_t decode_internal(input logic core,
                                                 input logic swap,
                                                 input logic [31:0] a);
    sad_route_t r;
    logic [7:0] win;
    logic [19:0] off;
    r = '0;
    win = a[27:20];
    off = a[19:0];
    r.valid = 1'b1;
    r.target = SAD_T_ABORT;
    r.offset = off[13:0];

    // Address zero: only the two core masters see a boot memory here.
    if (win == WIN_BOOT && core) begin
      if (swap) begin
        if (in_area(off, c_blocks)) begin
          r.target = SAD_T_SRAM;
          r.area = SAD_A_C;
          r.block = off[17:BLK_SHIFT];
        end
      end else if (boot_rom_ff) begin
        if (off < ROM_LIMIT) begin
          r.target = SAD_T_ROM;
        end
      end else begin
        r.target = SAD_T_EBI;
        r.cs = 8'h01;
      end

    // The three SRAM areas, each clipped to its configured size.
    end else if (win == WIN_SRAM_A &&
                 in_area(off, a_blocks_ff)) begin
      r.target = SAD_T_SRAM;
      r.area = SAD_A_A;
      r.block = off[17:BLK_SHIFT];
    end else if (win == WIN_SRAM_B &&
                 in_area(off, b_blocks_ff)) begin
      r.target = SAD_T_SRAM;
      r.area = SAD_A_B;
      r.block = off[17:BLK_SHIFT];
    end else if (win == WIN_SRAM_C &&
                 in_area(off, c_blocks)) begin
      r.target = SAD_T_SRAM;
      r.area = SAD_A_C;
      r.block = off[17:BLK_SHIFT];

    // ROM and the host register interfaces.
    end else if (win == WIN_ROM && off < ROM_LIMIT) begin
      r.target = SAD_T_ROM;
    end else if (win == WIN_USB_REGS || win == WIN_LCD_REGS) begin
      r.target = SAD_T_HOSTREG;
    end
    decode_internal = r;
  endfunction

  // Independent decoder for one master.
  function automatic sad_route_t decode(input logic [2:0] m,
                                        input logic [31:0] a);
    sad_route_t r;
    logic [3:0] region;
    logic core;
    logic swap;
    region = a[31:28];
    core = (m == M_INSTR) || (m == M_DATA);
    swap = (m == M_INSTR) ? remap_ff[0] : remap_ff[1];
    r = '0;
    r.valid = 1'b1;
    r.target = SAD_T_ABORT;
    r.offset = a[13:0];
    if (region == REG_INTERNAL) begin
      r = decode_internal(core, swap, a);
    end else if (region >= REG_EXT_FIRST && region <= REG_EXT_LAST) begin
      r.target = SAD_T_EBI;
      r.cs = 8'h01 << (region - REG_EXT_FIRST);
    end else if (region == REG_PERIPH) begin
      r.target = SAD_T_PERIPH;
    end
    decode = r;
  endfunction

  // Routes are latched at the start of a transfer and held to its end.
  genvar gm;
  generate
    for (gm = 0; gm < N_MASTERS; gm++) begin : g_master
      sad_route_t nxt_route;
      always_comb begin
        nxt_route = o_route[gm];
        if (i_req[gm].valid && !busy_ff[gm]) begin
          // Route available the next cycle: one-cycle decode.
          nxt_route = decode(3'(gm), i_req[gm].addr);
        end else if (i_done[gm]) begin
          nxt_route = '0;
        end
      end
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          o_route[gm] <= '0;
        end else begin
          o_route[gm] <= nxt_route;
        end
      end
      always_comb begin
        nxt_busy[gm] = busy_ff[gm];
        if (i_req[gm].valid && !busy_ff[gm]) begin
          nxt_busy[gm] = 1'b1;
        end else if (i_done[gm]) begin
          nxt_busy[gm] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_ff <= '0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  // Per-slave round-robin arbiters, each with its own pointer.
  // The pointer starts at the last master, so master 0 wins first.
  logic [N_SLAVES-1:0][2:0] last_ff;
  genvar gs;
  generate
    for (gs = 0; gs < N_SLAVES; gs++) begin : g_slave
      logic [N_MASTERS-1:0] want;
      logic [N_MASTERS-1:0] pick;
      always_comb begin
        logic [2:0] k;
        logic found;
        k = 3'h0;
        found = 1'b0;
        pick = '0;
        for (int m = 0; m < N_MASTERS; m++) begin
          want[m] = o_route[m].valid &&
                    (o_route[m].target == sad_target_t'(gs));
        end
        for (int j = 1; j <= N_MASTERS; j++) begin
          k = 3'((int'(last_ff[gs]) + j) % N_MASTERS);
          if (!found && want[k]) begin
            found = 1'b1;
            pick[k] = 1'b1;
          end
        end
      end
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          o_grant[gs] <= '0;
          last_ff[gs] <= 3'h4;
        end else begin
          // A grant is held until its owner stops asking.
          if (o_grant[gs] == '0 || (o_grant[gs] & want) == '0) begin
            o_grant[gs] <= pick;
            for (int m = 0; m < N_MASTERS; m++) begin
              if (pick[m]) begin
                last_ff[gs] <= 3'(m);
              end
            end
          end
        end
      end
    end
  endgenerate

  // Status copies are registered so that every output leaves a flip-flop.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_boot_rom <= 1'b0;
      o_sram_c_blocks <= N_BLOCKS;
    end else begin
      o_boot_rom <= boot_rom_ff;
      o_sram_c_blocks <= c_blocks;
    end
  end

endmodule

`default_nettype wire

// *** logic/sad_pkg.sv ***
// Package of constants and types for the system address decoder.
package sad_pkg;

  localparam int unsigned N_MASTERS = 5;
  localparam int unsigned N_SLAVES = 5;
  localparam int unsigned N_CS = 8;

  // Top-level region numbers, taken from address bits 31..28.
  localparam logic [3:0] REG_INTERNAL = 4'h0;
  localparam logic [3:0] REG_EXT_FIRST = 4'h1;
  localparam logic [3:0] REG_EXT_LAST = 4'h8;
  localparam logic [3:0] REG_PERIPH = 4'hf;

  // Second stage inside region zero, 1 Mbyte windows, bits 27..20.
  localparam logic [7:0] WIN_BOOT = 8'h00;
  localparam logic [7:0] WIN_SRAM_A = 8'h01;
  localparam logic [7:0] WIN_SRAM_B = 8'h02;
  localparam logic [7:0] WIN_SRAM_C = 8'h03;
  localparam logic [7:0] WIN_ROM = 8'h04;
  localparam logic [7:0] WIN_USB_REGS = 8'h05;
  localparam logic [7:0] WIN_LCD_REGS = 8'h06;

  // ROM is 32 Kbytes, SRAM blocks are 16 Kbytes.
  localparam logic [19:0] ROM_LIMIT = 20'h08000;
  localparam int unsigned BLK_SHIFT = 14;
  localparam logic [3:0] N_BLOCKS = 4'ha;
  localparam logic [3:0] C_FIXED_BLOCKS = 4'h2;

  // Master numbers.
  localparam logic [2:0] M_INSTR = 3'h0;
  localparam logic [2:0] M_DATA = 3'h1;

  // Size codes for SRAM A and SRAM B: 0, 16, 32 or 64 Kbytes.
  typedef enum logic [1:0] {
    SAD_SZ_0K = 2'b00,
    SAD_SZ_16K = 2'b01,
    SAD_SZ_32K = 2'b10,
    SAD_SZ_64K = 2'b11
  } sad_size_t;

  // Slave targets, with the matrix slave numbers, plus abort.
  typedef enum logic [2:0] {
    SAD_T_SRAM = 3'b000,
    SAD_T_ROM = 3'b001,
    SAD_T_HOSTREG = 3'b010,
    SAD_T_EBI = 3'b011,
    SAD_T_PERIPH = 3'b100,
    SAD_T_ABORT = 3'b111
  } sad_target_t;

  // SRAM area selected inside slave 0.
  typedef enum logic [1:0] {
    SAD_A_NONE = 2'b00,
    SAD_A_A = 2'b01,
    SAD_A_B = 2'b10,
    SAD_A_C = 2'b11
  } sad_area_t;

  // One master's request.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } sad_req_t;

  // One decoded route.
  typedef struct packed {
    logic valid;
    sad_target_t target;
    logic [7:0] cs;
    sad_area_t area;
    logic [3:0] block;
    logic [13:0] offset;
  } sad_route_t;

endpackage

// *** sim/sad_decoder_checker.sv ***
// Concurrent checks on the ports of the address decoder.
`timescale 1ns/1ps
`default_nettype none
module sad_decoder_checker
  import sad_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Inputs watched.
  input wire logic i_swap_bit_instr_master,
  input wire logic i_swap_bit_data_master,
  input wire sad_req_t [N_MASTERS-1:0] i_req,
  input wire logic [N_MASTERS-1:0] i_done,
  // Outputs watched.
  input wire sad_route_t [N_MASTERS-1:0] o_route,
  input wire logic [N_SLAVES-1:0][N_MASTERS-1:0] o_grant,
  input wire logic o_boot_rom
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // A request only opens a transfer while its master is idle.
  logic [N_MASTERS-1:0] tk;
  always_comb begin
    for (int m = 0; m < N_MASTERS; m++) tk[m] = i_req[m].valid && !o_route[m].valid;
  end
  AST_EXT_CS: assert property (
    tk[2] && i_req[2].addr[31:28] inside {[4'h1:4'h8]} |=>
    o_route[2].target == SAD_T_EBI &&
    o_route[2].cs == (8'h01 << ($past(i_req[2].addr[31:28]) - 4'h1)))
    else $error("chip select wrong");
  AST_ABORT: assert property (
    tk[3] && i_req[3].addr[31:28] inside {[4'h9:4'he]} |=>
    o_route[3].target == SAD_T_ABORT) else $error("no abort");
  AST_SRAM_C: assert property (
    tk[2] && i_req[2].addr[31:15] == 17'h00060 |=>
    o_route[2].target == SAD_T_SRAM && o_route[2].area == SAD_A_C)
    else $error("sram c base wrong");
  AST_ROM: assert property (
    tk[3] && i_req[3].addr[31:15] == 17'h00080 |=>
    o_route[3].target == SAD_T_ROM) else $error("rom base wrong");
  AST_BOOT: assert property (
    tk[0] && i_req[0].addr[31:15] == 17'h00000 && !i_swap_bit_instr_master |=>
    o_route[0].target == (o_boot_rom ? SAD_T_ROM : SAD_T_EBI))
    else $error("boot target wrong");
  AST_REMAP: assert property (
    tk[1] && i_req[1].addr[31:15] == 17'h00000 && i_swap_bit_data_master |=>
    o_route[1].target == SAD_T_SRAM && o_route[1].area == SAD_A_C)
    else $error("remap target wrong");
  AST_HOLD: assert property (
    o_route[0].valid && !i_done[0] |=> $stable(o_route[0]))
    else $error("route moved while open");
  AST_GRANT: assert property (
    $rose(o_route[3].valid) && o_route[3].target == SAD_T_ROM &&
    o_grant[1] == 5'h00 |=> o_grant[1] == 5'h08) else $error("no grant");
  cover property (o_route[1].valid && o_route[1].area == SAD_A_C);
  cover property (o_route[0].valid && i_done[0]);
  cover property (o_grant[1] != 5'h00);
endmodule
`default_nettype wire

// *** sim/sad_master_model.sv ***
// Bus master model that closes each routed transfer after a set wait.
`timescale 1ns/1ps
`default_nettype none
module sad_master_model
  import sad_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Routes seen and wait length in cycles.
  input wire sad_route_t [N_MASTERS-1:0] i_route,
  input wire logic [3:0] i_wait,
  // Completion pulses.
  output logic [N_MASTERS-1:0] o_done
);
  logic [N_MASTERS-1:0][3:0] cnt_ff;
  // Done lasts one cycle so a closed transfer is never closed twice.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
      o_done <= '0;
    end else begin
      for (int m = 0; m < N_MASTERS; m++) begin
        cnt_ff[m] <= (i_route[m].valid && !o_done[m]) ? cnt_ff[m] + 4'h1 : 4'h0;
        o_done[m] <= i_route[m].valid && !o_done[m] && cnt_ff[m] == i_wait;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench for the address decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sad_pkg::*;
  typedef struct packed {
    logic [2:0] m;
    logic [31:0] a;
    sad_target_t t;
    logic [7:0] x;
  } sad_row_t;
  logic i_mclk, i_rst_b, i_boot_memory_select;
  logic i_swap_bit_instr_master, i_swap_bit_data_master;
  sad_size_t i_size_sram_a, i_size_sram_b;
  sad_req_t [N_MASTERS-1:0] i_req;
  logic [N_MASTERS-1:0] i_done;
  sad_route_t [N_MASTERS-1:0] o_route;
  logic [N_SLAVES-1:0][N_MASTERS-1:0] o_grant;
  logic o_boot_rom;
  logic [3:0] o_sram_c_blocks, wt;
  int errors, compares;
  sad_route_t r;
  // Detail x is the chip select, or area and block for SRAM.
  sad_row_t rows[16] = '{
    '{3'h0, 32'h0000_0000, SAD_T_ROM, 8'h00},
    '{3'h1, 32'h1000_0000, SAD_T_EBI, 8'h01},
    '{3'h2, 32'h8fff_fffc, SAD_T_EBI, 8'h80},
    '{3'h3, 32'h9000_0000, SAD_T_ABORT, 8'h00},
    '{3'h4, 32'he000_0000, SAD_T_ABORT, 8'h00},
    '{3'h0, 32'hf000_0000, SAD_T_PERIPH, 8'h00},
    '{3'h2, 32'h0030_0000, SAD_T_SRAM, 8'h30},
    '{3'h4, 32'h0032_4000, SAD_T_SRAM, 8'h39},
    '{3'h4, 32'h0032_8000, SAD_T_ABORT, 8'h00},
    '{3'h3, 32'h0040_7ffc, SAD_T_ROM, 8'h00},
    '{3'h1, 32'h0040_8000, SAD_T_ABORT, 8'h00},
    '{3'h2, 32'h0050_0000, SAD_T_HOSTREG, 8'h00},
    '{3'h3, 32'h0060_0000, SAD_T_HOSTREG, 8'h00},
    '{3'h2, 32'h0000_0000, SAD_T_ABORT, 8'h00},
    '{3'h4, 32'h0010_0000, SAD_T_ABORT, 8'h00},
    '{3'h0, 32'h0070_0000, SAD_T_ABORT, 8'h00}};
  sad_decoder i_dut (.i_mclk, .i_rst_b, .i_boot_memory_select,
    .i_swap_bit_instr_master, .i_swap_bit_data_master, .i_size_sram_a,
    .i_size_sram_b, .i_req, .i_done, .o_route, .o_grant, .o_boot_rom,
    .o_sram_c_blocks);
  sad_master_model i_mm (.i_mclk, .i_rst_b, .i_route(o_route), .i_wait(wt),
    .o_done(i_done));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic cmp_t(input sad_target_t g, input sad_target_t e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_n(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Contents are never relied on across a repartition.
  task automatic row(input sad_row_t w);
    @(posedge i_mclk);
    i_req[w.m] <= '{1'b1, w.a};
    @(posedge i_mclk);
    i_req[w.m].valid <= 1'b0;
    repeat (20) if (o_route[w.m].valid !== 1'b1) @(negedge i_mclk);
    r = o_route[w.m];
    repeat (40) if (o_route[w.m].valid !== 1'b0) @(negedge i_mclk);
    cmp_t(r.target, w.t);
    if (w.t == SAD_T_EBI) cmp_n(r.cs, w.x);
    if (w.t == SAD_T_SRAM) cmp_n({2'b00, r.area, r.block}, w.x);
  endtask
  task automatic cfg(input sad_size_t a, input sad_size_t b, input logic [3:0] c);
    @(posedge i_mclk);
    i_size_sram_a <= a;
    i_size_sram_b <= b;
    repeat (3) @(posedge i_mclk);
    cmp_n({4'h0, o_sram_c_blocks}, {4'h0, c});
  endtask
  task automatic rst(input logic s);
    i_rst_b <= 1'b0;
    i_boot_memory_select <= s;
    repeat (3) @(posedge i_mclk);
    cmp_n({4'h0, o_sram_c_blocks}, 8'h0a);
    i_rst_b <= 1'b1;
    repeat (5) @(posedge i_mclk);
    cmp_n({7'h00, o_boot_rom}, {7'h00, s});
  endtask
  task automatic results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_swap_bit_instr_master = 1'b0;
    i_swap_bit_data_master = 1'b0;
    i_size_sram_a = SAD_SZ_0K;
    i_size_sram_b = SAD_SZ_0K;
    i_req = '0;
    wt = 4'h0;
    errors = 0;
    compares = 0;
    rst(1'b1);
    foreach (rows[i]) row(rows[i]);
    @(posedge i_mclk);
    i_swap_bit_instr_master <= 1'b1;
    row('{3'h0, 32'h0000_0000, SAD_T_SRAM, 8'h30});
    row('{3'h1, 32'h0000_0000, SAD_T_ROM, 8'h00});
    @(posedge i_mclk);
    i_swap_bit_data_master <= 1'b1;
    row('{3'h1, 32'h0000_4000, SAD_T_SRAM, 8'h31});
    cfg(SAD_SZ_64K, SAD_SZ_32K, 4'h4);
    row('{3'h2, 32'h0010_c000, SAD_T_SRAM, 8'h13});
    row('{3'h3, 32'h0020_4000, SAD_T_SRAM, 8'h21});
    row('{3'h3, 32'h0020_8000, SAD_T_ABORT, 8'h00});
    row('{3'h4, 32'h0030_c000, SAD_T_SRAM, 8'h33});
    row('{3'h4, 32'h0031_0000, SAD_T_ABORT, 8'h00});
    cfg(SAD_SZ_64K, SAD_SZ_64K, 4'h2);
    row('{3'h0, 32'h0000_8000, SAD_T_ABORT, 8'h00});
    // A slow master; a second request while open must be ignored.
    @(posedge i_mclk);
    wt <= 4'h6;
    i_req[0] <= '{1'b1, 32'h1000_0000};
    @(posedge i_mclk);
    i_req[0].valid <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_req[0] <= '{1'b1, 32'hf000_0000};
    @(posedge i_mclk);
    i_req[0].valid <= 1'b0;
    @(negedge i_mclk);
    cmp_t(o_route[0].target, SAD_T_EBI);
    repeat (30) if (o_route[0].valid !== 1'b0) @(negedge i_mclk);
    @(posedge i_mclk);
    i_swap_bit_instr_master <= 1'b0;
    rst(1'b0);
    row('{3'h0, 32'h0000_0000, SAD_T_EBI, 8'h01});
    results;
  end
  initial begin
    repeat (3000) @(posedge i_mclk);
    errors++;
    results;
  end
endmodule
bind sad_decoder sad_decoder_checker i_chk (.i_mclk, .i_rst_b,
  .i_swap_bit_instr_master, .i_swap_bit_data_master, .i_req, .i_done,
  .o_route, .o_grant, .o_boot_rom);
`default_nettype wire
